// ---- include/chb_pkg.sv ----
// chb_pkg: constants, register layouts and carriers of the channel b controller
// assumes a 10 MHz sys_clk_i and a 32-bit register port with word addresses
package chb_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int MODE_W = 3;
  localparam int TARGET_W = 8;
  localparam int PEAK_W = 4;
  localparam int PEAK_LOW_W = 2;
  localparam int PEAK_IDX_W = 5;
  localparam int SPACE_W = 4;
  localparam int TON_W = 4;
  localparam int THR_W = 4;
  localparam int GAIN_W = 5;
  localparam int START_W = 2;
  localparam int CNT_W = 12;
  localparam int TMR_W = 8;
  localparam int HOLD_W = 2;
  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_B = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PEAK = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PULSE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_LINEAR = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_AC = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;
  // mode field encodings
  localparam logic [MODE_W-1:0] B_MODE_BUCK = 3'h1;
  localparam logic [MODE_W-1:0] B_MODE_LINEAR = 3'h2;
  localparam logic [MODE_W-1:0] B_MODE_PARALLEL = 3'h3;
  localparam logic [MODE_W-1:0] A_MODE_PARALLEL = 3'h5;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SPACE_UNIT_NS = 300;
  localparam int SPACE_UNIT_CYC = (SPACE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TON_UNIT_NS = 70;
  localparam int TON_STEP = 4;
  localparam int PEAK_DELAY_NS = 25;
  localparam int PEAK_DELAY_CYC =
    (PEAK_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : PEAK_DELAY_NS / CLK_PERIOD_NS;
  localparam int LIN_PULSE_CYC_DEF = 4;
  localparam int LOW_PEAK_MULT = 4;
  localparam int LOW_PEAK_OFFSET = 2;

  typedef struct packed {
    logic linear_c_standalone_enable;
    logic [MODE_W-1:0] channel_a_mode_select;
    logic [MODE_W-1:0] channel_b_mode_select;
  } mode_reg_t;
  typedef struct packed {
    logic [TARGET_W-1:0] out_b_target_low_power;
    logic [TARGET_W-1:0] out_b_target_full_power;
  } target_b_reg_t;
  typedef struct packed {
    logic [TARGET_W-1:0] out_c_target;
    logic [TARGET_W-1:0] out_a_target;
  } target_ac_reg_t;
  typedef struct packed {
    logic [PEAK_LOW_W-1:0] channel_b_peak_code_low;
    logic [PEAK_W-1:0] channel_b_peak_code_full;
  } peak_reg_t;
  typedef struct packed {
    logic [THR_W-1:0] switch_to_linear_threshold;
    logic [TON_W-1:0] channel_b_on_time_cap;
    logic spacing_enable;
    logic [SPACE_W-1:0] channel_b_pulse_spacing;
  } pulse_reg_t;
  typedef struct packed {
    logic [START_W-1:0] linear_c_startup_current;
    logic [GAIN_W-1:0] linear_c_current_gain;
    logic [START_W-1:0] linear_b_startup_current;
    logic [GAIN_W-1:0] linear_b_current_gain;
  } linear_reg_t;
  typedef struct packed {
    logic [CNT_W-1:0] count_c;
    logic [CNT_W-1:0] count_b;
    logic low_power_applied;
    logic linear_c_on;
    logic linear_b_on;
    logic switching;
  } status_reg_t;
  typedef struct packed {
    logic [TARGET_W-1:0] target_code;
    logic [PEAK_IDX_W-1:0] peak_index;
  } op_point_t;

  // inrush limiting starts on, so a cold start is current limited by default
  localparam pulse_reg_t PULSE_RESET = '{spacing_enable: 1'b1, default: '0};

  function automatic logic [TMR_W-1:0] space_cycles(input logic [SPACE_W-1:0] code);
    return TMR_W'(SPACE_UNIT_CYC * (2 * int'(code) + 1));
  endfunction

  // longest time, so rounded down, never under one cycle
  function automatic logic [TMR_W-1:0] on_time_cycles(input logic [TON_W-1:0] code);
    int cyc;
    cyc = (TON_UNIT_NS * (1 + TON_STEP * int'(code))) / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return TMR_W'(cyc);
  endfunction

  function automatic logic [PEAK_IDX_W-1:0] low_peak_index(input logic [PEAK_LOW_W-1:0] code);
    return PEAK_IDX_W'(LOW_PEAK_MULT * int'(code) + LOW_PEAK_OFFSET);
  endfunction
endpackage

// ---- logic/interval_timer.sv ----
// interval_timer: reloadable down counter, busy while nonzero
// assumes load and count are synchronous to sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module interval_timer #(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  // status
  output logic busy_o
);
  logic [WIDTH-1:0] count_r;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
    end else if (ce_i) begin
      if (load_i) begin
        count_r <= count_i;
      end else if (count_r != '0) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  assign busy_o = (count_r != '0);
endmodule // interval_timer
`default_nettype wire

// ---- logic/op_select.sv ----
// op_select: picks the target and peak codes for the present energy state
// assumes the codes come straight from the configuration registers
`timescale 1ns/10ps
`default_nettype none
module op_select (
  // energy state
  input wire logic low_power_i,
  // configuration
  input wire chb_pkg::target_b_reg_t target_i,
  input wire chb_pkg::peak_reg_t peak_i,
  // selected operating point
  output chb_pkg::op_point_t op_o
);
  always_comb begin
    if (low_power_i) begin
      op_o.target_code = target_i.out_b_target_low_power;
      op_o.peak_index = chb_pkg::low_peak_index(peak_i.channel_b_peak_code_low);
    end else begin
      op_o.target_code = target_i.out_b_target_full_power;
      op_o.peak_index = chb_pkg::PEAK_IDX_W'(peak_i.channel_b_peak_code_full);
    end
  end
endmodule // op_select
`default_nettype wire

// ---- logic/buck_b_ctrl.sv ----
// buck_b_ctrl: pulse control of the step-down channel b with its linear
// regulator, plus the linear regulator c that may pair with channel a
// assumes comparator inputs are synchronous to sys_clk_i and that the
// analog stage turns target and peak codes into levels
`timescale 1ns/10ps
`default_nettype none
module buck_b_ctrl #(
  parameter int LIN_PULSE_CYC = chb_pkg::LIN_PULSE_CYC_DEF
) (
  // clock, reset and enable
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [chb_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [chb_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [chb_pkg::DATA_W-1:0] reg_rdata_o,
  // energy state
  input wire logic low_power_i,
  // channel b comparators
  input wire logic demand_b_i,
  input wire logic peak_reached_i,
  input wire logic zero_cross_i,
  input wire logic headroom_b_low_i,
  input wire logic in_reg_b_i,
  // linear c comparators
  input wire logic demand_c_i,
  input wire logic headroom_a_low_i,
  input wire logic in_reg_c_i,
  // channel b stage
  output logic high_side_on_o,
  output logic low_side_on_o,
  output logic linear_b_pulse_o,
  output chb_pkg::op_point_t op_point_b_o,
  output logic [chb_pkg::THR_W-1:0] switch_to_linear_threshold_o,
  output logic [chb_pkg::GAIN_W-1:0] linear_b_current_gain_o,
  output logic [chb_pkg::START_W-1:0] linear_b_startup_current_o,
  output logic linear_b_startup_active_o,
  // linear c stage
  output logic linear_c_pulse_o,
  output logic linear_c_parallel_o,
  output logic [chb_pkg::TARGET_W-1:0] linear_c_target_o,
  output logic [chb_pkg::GAIN_W-1:0] linear_c_current_gain_o,
  output logic [chb_pkg::START_W-1:0] linear_c_startup_current_o,
  output logic linear_c_startup_active_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHARGE,
    ST_PEAK_HOLD,
    ST_DISCHARGE,
    ST_LINEAR
  } pulse_state_t;

  pulse_state_t state_r;
  chb_pkg::mode_reg_t mode_r;
  chb_pkg::target_b_reg_t target_b_r;
  chb_pkg::target_ac_reg_t target_ac_r;
  chb_pkg::peak_reg_t peak_r;
  chb_pkg::pulse_reg_t pulse_r;
  chb_pkg::linear_reg_t linear_r;
  chb_pkg::status_reg_t status;
  chb_pkg::op_point_t op_sel;
  chb_pkg::op_point_t op_r;
  logic [chb_pkg::HOLD_W-1:0] hold_r;
  logic [chb_pkg::CNT_W-1:0] count_b_r;
  logic [chb_pkg::CNT_W-1:0] count_c_r;
  logic low_power_applied_r;
  logic c_on_r;
  logic reached_b_r;
  logic reached_c_r;
  logic b_enabled;
  logic b_linear_used;
  logic start_b;
  logic start_linear;
  logic cap_on;
  logic cap_hit;
  logic space_busy;
  logic ton_busy;
  logic lc_busy;
  logic c_parallel;
  logic c_enabled;
  logic start_c;
  logic status_wr;
  logic [chb_pkg::TMR_W-1:0] ton_load;

  function automatic logic parallel_takeover(input logic [chb_pkg::MODE_W-1:0] mode,
                                             input logic [chb_pkg::MODE_W-1:0] par_code,
                                             input logic headroom_low);
    return (mode == par_code) && headroom_low;
  endfunction

  // configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode_r <= '0;
      target_b_r <= '0;
      target_ac_r <= '0;
      peak_r <= '0;
      pulse_r <= chb_pkg::PULSE_RESET;
      linear_r <= '0;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        chb_pkg::ADDR_MODE: begin
          mode_r <= chb_pkg::mode_reg_t'(reg_wdata_i[$bits(chb_pkg::mode_reg_t)-1:0]);
        end
        chb_pkg::ADDR_TARGET_B: begin
          target_b_r <=
            chb_pkg::target_b_reg_t'(reg_wdata_i[$bits(chb_pkg::target_b_reg_t)-1:0]);
        end
        chb_pkg::ADDR_TARGET_AC: begin
          target_ac_r <=
            chb_pkg::target_ac_reg_t'(reg_wdata_i[$bits(chb_pkg::target_ac_reg_t)-1:0]);
        end
        chb_pkg::ADDR_PEAK: begin
          peak_r <= chb_pkg::peak_reg_t'(reg_wdata_i[$bits(chb_pkg::peak_reg_t)-1:0]);
        end
        chb_pkg::ADDR_PULSE: begin
          pulse_r <= chb_pkg::pulse_reg_t'(reg_wdata_i[$bits(chb_pkg::pulse_reg_t)-1:0]);
        end
        chb_pkg::ADDR_LINEAR: begin
          linear_r <= chb_pkg::linear_reg_t'(reg_wdata_i[$bits(chb_pkg::linear_reg_t)-1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  assign status_wr = reg_wr_i && (reg_addr_i == chb_pkg::ADDR_STATUS);

  // read data stand only in the cycle after the strobe; unmapped words read zero
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          chb_pkg::ADDR_MODE: reg_rdata_o <= chb_pkg::DATA_W'(mode_r);
          chb_pkg::ADDR_TARGET_B: reg_rdata_o <= chb_pkg::DATA_W'(target_b_r);
          chb_pkg::ADDR_TARGET_AC: reg_rdata_o <= chb_pkg::DATA_W'(target_ac_r);
          chb_pkg::ADDR_PEAK: reg_rdata_o <= chb_pkg::DATA_W'(peak_r);
          chb_pkg::ADDR_PULSE: reg_rdata_o <= chb_pkg::DATA_W'(pulse_r);
          chb_pkg::ADDR_LINEAR: reg_rdata_o <= chb_pkg::DATA_W'(linear_r);
          chb_pkg::ADDR_STATUS: reg_rdata_o <= chb_pkg::DATA_W'(status);
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // mode decode; any code other than the three step-down ones keeps the channel off
  assign b_enabled = (mode_r.channel_b_mode_select == chb_pkg::B_MODE_BUCK) ||
                     (mode_r.channel_b_mode_select == chb_pkg::B_MODE_LINEAR) ||
                     (mode_r.channel_b_mode_select == chb_pkg::B_MODE_PARALLEL);
  assign b_linear_used = (mode_r.channel_b_mode_select == chb_pkg::B_MODE_LINEAR) ||
                         (mode_r.channel_b_mode_select == chb_pkg::B_MODE_PARALLEL);
  // the headroom comparator compares against the threshold driven out below
  assign start_linear = (mode_r.channel_b_mode_select == chb_pkg::B_MODE_LINEAR) ||
                        parallel_takeover(mode_r.channel_b_mode_select,
                                          chb_pkg::B_MODE_PARALLEL, headroom_b_low_i);
  assign start_b = (state_r == ST_IDLE) && b_enabled && demand_b_i && !space_busy;
  assign cap_on = (pulse_r.channel_b_on_time_cap != '0);
  assign cap_hit = cap_on && !ton_busy;
  assign ton_load = start_linear ?
                    chb_pkg::TMR_W'(LIN_PULSE_CYC - 1) :
                    chb_pkg::TMR_W'(chb_pkg::on_time_cycles(pulse_r.channel_b_on_time_cap) - 1);

  op_select u_op_select (
    .low_power_i(low_power_i),
    .target_i(target_b_r),
    .peak_i(peak_r),
    .op_o(op_sel)
  );

  // spacing runs from one pulse start to the next, switching or linear alike
  interval_timer #(
    .WIDTH(chb_pkg::TMR_W)
  ) u_space_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .load_i(start_b && pulse_r.spacing_enable),
    .count_i(chb_pkg::TMR_W'(chb_pkg::space_cycles(pulse_r.channel_b_pulse_spacing) - 1)),
    .busy_o(space_busy)
  );

  // one timer serves the on-time cap and the linear pulse length
  interval_timer #(
    .WIDTH(chb_pkg::TMR_W)
  ) u_ton_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .load_i(start_b),
    .count_i(ton_load),
    .busy_o(ton_busy)
  );

  // channel b pulse sequence
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          if (start_b) begin
            state_r <= start_linear ? ST_LINEAR : ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          if (cap_hit) begin
            state_r <= ST_DISCHARGE;
          end else if (peak_reached_i) begin
            state_r <= ST_PEAK_HOLD;
          end
        end
        ST_PEAK_HOLD: begin
          if (hold_r == '0) begin
            state_r <= ST_DISCHARGE;
          end
        end
        ST_DISCHARGE: begin
          if (zero_cross_i) begin
            state_r <= ST_IDLE;
          end
        end
        ST_LINEAR: begin
          if (!ton_busy) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // response delay after the peak comparator, so the real peak overshoots the base
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      hold_r <= '0;
    end else if (ce_i) begin
      if (state_r == ST_CHARGE) begin
        hold_r <= chb_pkg::HOLD_W'(chb_pkg::PEAK_DELAY_CYC - 1);
      end else if (hold_r != '0) begin
        hold_r <= hold_r - 1'b1;
      end
    end
  end

  // codes track the energy state while idle and freeze for the pulse in flight
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      op_r <= '0;
      low_power_applied_r <= 1'b0;
    end else if (ce_i && state_r == ST_IDLE) begin
      op_r <= op_sel;
      low_power_applied_r <= low_power_i;
    end
  end

  assign high_side_on_o = (state_r == ST_CHARGE) || (state_r == ST_PEAK_HOLD);
  assign low_side_on_o = (state_r == ST_DISCHARGE);
  assign linear_b_pulse_o = (state_r == ST_LINEAR);
  assign op_point_b_o = op_r;
  assign switch_to_linear_threshold_o = pulse_r.switch_to_linear_threshold;
  assign linear_b_current_gain_o = linear_r.linear_b_current_gain;
  assign linear_b_startup_current_o = linear_r.linear_b_startup_current;
  assign linear_c_current_gain_o = linear_r.linear_c_current_gain;
  assign linear_c_startup_current_o = linear_r.linear_c_startup_current;

  // linear c: parallel with channel a beats the standalone enable
  assign c_parallel = (mode_r.channel_a_mode_select == chb_pkg::A_MODE_PARALLEL);
  assign c_enabled = c_parallel || mode_r.linear_c_standalone_enable;
  assign start_c = demand_c_i && !c_on_r && (c_parallel ?
                   parallel_takeover(mode_r.channel_a_mode_select,
                                     chb_pkg::A_MODE_PARALLEL, headroom_a_low_i) :
                   mode_r.linear_c_standalone_enable);

  interval_timer #(
    .WIDTH(chb_pkg::TMR_W)
  ) u_lc_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .load_i(start_c),
    .count_i(chb_pkg::TMR_W'(LIN_PULSE_CYC - 1)),
    .busy_o(lc_busy)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      c_on_r <= 1'b0;
    end else if (ce_i) begin
      if (start_c) begin
        c_on_r <= 1'b1;
      end else if (!lc_busy) begin
        c_on_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      linear_c_parallel_o <= 1'b0;
      linear_c_target_o <= '0;
    end else if (ce_i) begin
      linear_c_parallel_o <= c_parallel;
      linear_c_target_o <= c_parallel ? target_ac_r.out_a_target :
                                        target_ac_r.out_c_target;
    end
  end

  assign linear_c_pulse_o = c_on_r;

  // startup limit holds until the output first reaches target; disabling rearms it
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      reached_b_r <= 1'b0;
      reached_c_r <= 1'b0;
    end else if (ce_i) begin
      reached_b_r <= b_linear_used && (reached_b_r || in_reg_b_i);
      reached_c_r <= c_enabled && (reached_c_r || in_reg_c_i);
    end
  end

  assign linear_b_startup_active_o = !reached_b_r;
  assign linear_c_startup_active_o = !reached_c_r;

  // pulse counters wrap; a status write clears them but a pulse in that cycle still counts
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      count_b_r <= '0;
      count_c_r <= '0;
    end else if (ce_i) begin
      if (start_b) begin
        count_b_r <= status_wr ? chb_pkg::CNT_W'(1) : count_b_r + 1'b1;
      end else if (status_wr) begin
        count_b_r <= '0;
      end
      if (start_c) begin
        count_c_r <= status_wr ? chb_pkg::CNT_W'(1) : count_c_r + 1'b1;
      end else if (status_wr) begin
        count_c_r <= '0;
      end
    end
  end

  always_comb begin
    status.count_c = count_c_r;
    status.count_b = count_b_r;
    status.low_power_applied = low_power_applied_r;
    status.linear_c_on = c_on_r;
    status.linear_b_on = (state_r == ST_LINEAR);
    status.switching = (state_r == ST_CHARGE) || (state_r == ST_PEAK_HOLD) ||
                       (state_r == ST_DISCHARGE);
  end
endmodule // buck_b_ctrl
`default_nettype wire

// ---- verif/buck_b_monitor.sv ----
// buck_b_monitor: port-level assertions for buck_b_ctrl
// assumes one clock, ce_i held high and configuration written while idle
`timescale 1ns/10ps
`default_nettype none
module buck_b_monitor #(
  parameter int LIN_PULSE_CYC = 4
) (
  // clock, reset, register writes
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [chb_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [chb_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // comparators
  input wire logic peak_reached_i,
  input wire logic zero_cross_i,
  input wire logic headroom_b_low_i,
  input wire logic in_reg_b_i,
  input wire logic demand_c_i,
  input wire logic headroom_a_low_i,
  // stage drive
  input wire logic high_side_on_o,
  input wire logic low_side_on_o,
  input wire logic linear_b_pulse_o,
  input wire logic linear_c_pulse_o,
  input wire logic linear_b_startup_active_o
);
  logic [6:0] mode_r;
  logic [12:0] pul_r;
  int gap_r;
  int hi_r;
  int lb_r;
  int cap_c;
  logic start_w;
  // shadow copies of the mode and pulse words, taken from the write port
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode_r <= '0;
      pul_r <= 13'h0010;
    end else if (reg_wr_i && reg_addr_i == chb_pkg::ADDR_MODE) begin
      mode_r <= reg_wdata_i[6:0];
    end else if (reg_wr_i && reg_addr_i == chb_pkg::ADDR_PULSE) begin
      pul_r <= reg_wdata_i[12:0];
    end
  end
  assign start_w = (high_side_on_o && hi_r == 0) || (linear_b_pulse_o && lb_r == 0);
  assign cap_c = (70 * (1 + 4 * int'(pul_r[8:5]))) / 100;
  always_ff @(posedge sys_clk_i) begin
    hi_r <= high_side_on_o ? hi_r + 1 : 0;
    lb_r <= linear_b_pulse_o ? lb_r + 1 : 0;
    gap_r <= !reset_n_i ? 999 : (start_w ? 1 : gap_r + 1);
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_hold;
    high_side_on_o ##1 (!high_side_on_o && low_side_on_o);
  endsequence
  property p_mode;
    $rose(high_side_on_o) |-> $past(mode_r[2:0]) inside {3'h1, 3'h3};
  endproperty
  a_mode: assert property (p_mode) else $error("switching in wrong mode");
  property p_excl;
    !(high_side_on_o && low_side_on_o);
  endproperty
  a_excl: assert property (p_excl) else $error("both switches on");
  property p_zero;
    low_side_on_o && zero_cross_i |=> !low_side_on_o;
  endproperty
  a_zero: assert property (p_zero) else $error("discharge past zero");
  property p_peak;
    high_side_on_o && peak_reached_i && !$past(peak_reached_i) |=> s_hold;
  endproperty
  a_peak: assert property (p_peak) else $error("peak hold wrong");
  property p_space;
    start_w && pul_r[4] |-> gap_r >= 3 * (2 * int'(pul_r[3:0]) + 1);
  endproperty
  a_space: assert property (p_space) else $error("pulse starts too close");
  property p_cap;
    high_side_on_o && pul_r[8:5] != 4'h0 |-> hi_r < cap_c;
  endproperty
  a_cap: assert property (p_cap) else $error("on time over cap");
  property p_hand;
    $rose(high_side_on_o || linear_b_pulse_o) && $past(mode_r[2:0]) == 3'h3
      |-> $past(headroom_b_low_i) == linear_b_pulse_o;
  endproperty
  a_hand: assert property (p_hand) else $error("handover wrong");
  property p_lin_len;
    $fell(linear_b_pulse_o) |-> lb_r == LIN_PULSE_CYC;
  endproperty
  a_lin_len: assert property (p_lin_len) else $error("linear pulse length");
  property p_c_gate;
    $rose(linear_c_pulse_o) |-> $past(demand_c_i) && ($past(mode_r[5:3]) == 3'h5 ?
      $past(headroom_a_low_i) : $past(mode_r[6]));
  endproperty
  a_c_gate: assert property (p_c_gate) else $error("linear c gate");
  property p_start;
    $fell(linear_b_startup_active_o) |-> $past(in_reg_b_i);
  endproperty
  a_start: assert property (p_start) else $error("startup ended early");
endmodule // buck_b_monitor
bind buck_b_ctrl buck_b_monitor #(.LIN_PULSE_CYC(LIN_PULSE_CYC)) mon (.sys_clk_i, .reset_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .peak_reached_i, .zero_cross_i, .headroom_b_low_i,
  .in_reg_b_i, .demand_c_i, .headroom_a_low_i, .high_side_on_o, .low_side_on_o,
  .linear_b_pulse_o, .linear_c_pulse_o, .linear_b_startup_active_o);
`default_nettype wire

// ---- verif/stage_model.sv ----
// stage_model: inductor and load of channel b seen through its comparators
// assumes switch drives come from buck_b_ctrl on the same clock
`timescale 1ns/10ps
`default_nettype none
module stage_model (
  // clock and speed
  input wire logic sys_clk_i,
  input wire logic slow_i,
  // switches
  input wire logic high_side_on_i,
  input wire logic low_side_on_i,
  // comparators
  output logic peak_reached_o,
  output logic zero_cross_o
);
  logic [3:0] h_r;
  logic [3:0] l_r;
  always_ff @(posedge sys_clk_i) begin
    h_r <= high_side_on_i ? h_r + 4'h1 : 4'h0;
    l_r <= low_side_on_i ? l_r + 4'h1 : 4'h0;
  end
  // slow input: headroom too small to ever reach peak, only a cap ends charge
  assign peak_reached_o = high_side_on_i && h_r >= 4'h3 && !slow_i;
  assign zero_cross_o = low_side_on_i && l_r >= 4'h2;
endmodule // stage_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// tb_top: register-port tests of buck_b_ctrl with a stage model
// assumes the monitor is bound to every buck_b_ctrl
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic low_power_i = 1'b0;
  logic demand_b_i = 1'b0;
  logic demand_c_i = 1'b0;
  logic headroom_b_low_i = 1'b0;
  logic headroom_a_low_i = 1'b0;
  logic in_reg_b_i = 1'b0;
  logic slow = 1'b0;
  logic peak, zero, hs_on, ls_on, lb_on, lc_on, lc_par, sb_act, sc_act;
  logic [3:0] thr;
  logic [4:0] gb, gc;
  logic [1:0] sb, sc;
  logic [7:0] ct;
  chb_pkg::op_point_t op;
  int miscompares = 0;
  int checked = 0;
  int hs, lb, lc, hcur, hlen;
  logic [2:0] prv = '0;
  logic [31:0] mk [6] = '{32'h7f, 32'hffff, 32'h3f, 32'h1fff, 32'h3fff, 32'hffff};
  logic [11:0] tc [8] = '{12'h87f, 12'h201, 12'h483, 12'h203, 12'h402, 12'h928,
    12'h068, 12'h840};
  always #50 sys_clk_i = ~sys_clk_i;
  buck_b_ctrl uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .low_power_i(low_power_i),
    .demand_b_i(demand_b_i), .peak_reached_i(peak), .zero_cross_i(zero),
    .headroom_b_low_i(headroom_b_low_i), .in_reg_b_i(in_reg_b_i), .demand_c_i(demand_c_i),
    .headroom_a_low_i(headroom_a_low_i), .in_reg_c_i(in_reg_b_i), .high_side_on_o(hs_on),
    .low_side_on_o(ls_on), .linear_b_pulse_o(lb_on), .op_point_b_o(op),
    .switch_to_linear_threshold_o(thr), .linear_b_current_gain_o(gb),
    .linear_b_startup_current_o(sb), .linear_b_startup_active_o(sb_act),
    .linear_c_pulse_o(lc_on), .linear_c_parallel_o(lc_par), .linear_c_target_o(ct),
    .linear_c_current_gain_o(gc), .linear_c_startup_current_o(sc),
    .linear_c_startup_active_o(sc_act));
  stage_model pm (.sys_clk_i(sys_clk_i), .slow_i(slow), .high_side_on_i(hs_on),
    .low_side_on_i(ls_on), .peak_reached_o(peak), .zero_cross_o(zero));
  always @(posedge sys_clk_i) begin
    if (hs_on && !prv[0]) hs++;
    if (lb_on && !prv[1]) lb++;
    if (lc_on && !prv[2]) lc++;
    hcur = hs_on ? hcur + 1 : 0;
    if (hcur > 0) hlen = hcur;
    prv = {lc_on, lb_on, hs_on};
  end
  task automatic final_report();
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rdata", e, reg_rdata_o);
    @(posedge sys_clk_i);
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge sys_clk_i);
      if (!(hs_on || ls_on || lb_on || lc_on)) break;
    end
    if (i == 60) begin
      miscompares++;
      final_report();
    end
    @(posedge sys_clk_i);
  endtask
  // both demands held for a window while pulse starts are counted, then which kinds started at all is compared with the pattern in t[11:9]
  task automatic run(input logic [11:0] t);
    wr(chb_pkg::ADDR_MODE, {25'h0, t[6:0]});
    headroom_b_low_i <= t[7];
    headroom_a_low_i <= t[8];
    hs = 0;
    lb = 0;
    lc = 0;
    demand_b_i <= 1'b1;
    demand_c_i <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    demand_b_i <= 1'b0;
    demand_c_i <= 1'b0;
    idle();
    chk("starts", {29'h0, t[11:9]}, {29'h0, lc != 0, lb != 0, hs != 0});
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(chb_pkg::ADDR_PULSE, 32'h10);
    for (int i = 0; i < 6; i++) begin
      wr(4'(i), 32'hffffffff);
      rd(4'(i), mk[i]);
    end
    wr(4'h9, 32'hffffffff);
    rd(4'h9, 32'h0);
    chk("gains", 32'h3ff, {gc, gb});
    chk("thr start", 32'hff, {thr, sc, sb});
    wr(chb_pkg::ADDR_MODE, 32'h2);
    wr(chb_pkg::ADDR_TARGET_B, 32'h2112);
    wr(chb_pkg::ADDR_PEAK, 32'h39);
    low_power_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk("op full", {19'h0, 8'h12, 5'h09}, 32'(op));
    low_power_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk("op low", {19'h0, 8'h21, 5'd14}, 32'(op));
    low_power_i <= 1'b0;
    wr(chb_pkg::ADDR_PULSE, 32'h12);
    wr(chb_pkg::ADDR_TARGET_AC, 32'h5634);
    for (int i = 0; i < 8; i++) run(tc[i]);
    wr(chb_pkg::ADDR_MODE, 32'h28);
    repeat (2) @(posedge sys_clk_i);
    chk("c par", 32'h134, {lc_par, ct});
    wr(chb_pkg::ADDR_MODE, 32'h40);
    repeat (2) @(posedge sys_clk_i);
    chk("c alone", 32'h056, {lc_par, ct});
    wr(chb_pkg::ADDR_PULSE, 32'h60);
    slow <= 1'b1;
    run(12'h201);
    chk("on time", 32'd9, hlen);
    wr(chb_pkg::ADDR_MODE, 32'h2);
    chk("startup", 32'h3, {30'h0, sc_act, sb_act});
    in_reg_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk("startup", 32'h2, {30'h0, sc_act, sb_act});
    final_report();
  end
endmodule // tb_top
`default_nettype wire
